// *** hdl/zlek_pkg.sv ***
package zlek_pkg;

   // ---------------------------------------------------------------
   // lock and policy byte values
   // ---------------------------------------------------------------
   localparam logic [7:0] LOCK_OPEN     = 8'h55; // unlocked marker
   localparam logic [7:0] LOCK_SHUT     = 8'h00; // written by lock command
   localparam logic [7:0] POL_READONLY  = 8'hAA; // locked read-only policy
   localparam logic [7:0] POL_CONSUME   = 8'h55; // one-way fuse policy
   localparam logic [7:0] POL_LEGACY    = 8'h00; // legacy fuse policy
   localparam logic [7:0] POL_RESET     = 8'hAA; // policy byte after reset

   // ---------------------------------------------------------------
   // configuration zone byte addresses
   // ---------------------------------------------------------------
   localparam logic [6:0] CFG_DATA_LOCK  = 7'h56; // byte 86
   localparam logic [6:0] CFG_CFG_LOCK   = 7'h57; // byte 87
   localparam logic [6:0] CFG_POLICY     = 7'h11; // byte 17
   localparam logic [6:0] CFG_FIXED_LAST = 7'h0C; // bytes 0..12 never written

   // ---------------------------------------------------------------
   // one-time-programmable zone
   // ---------------------------------------------------------------
   localparam int          OTP_WORDS    = 16;
   localparam logic [31:0] OTP_RESET    = 32'hFFFFFFFF; // as delivered
   localparam logic [3:0]  LEGACY_LAST  = 4'h1;         // words 0..1 hidden

   // ---------------------------------------------------------------
   // register port map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CFG_LOCK  = 8'h00;
   localparam logic [7:0] REG_DATA_LOCK = 8'h04;
   localparam logic [7:0] REG_POLICY    = 8'h08;
   localparam logic [7:0] REG_STATUS    = 8'h0C;
   localparam logic [7:0] REG_LOCK_CMD  = 8'h10;
   localparam logic [7:0] REG_FIXED     = 8'h14;
   localparam int         LOCKCMD_CFG   = 0;
   localparam int         LOCKCMD_DATA  = 1;
   localparam int         ST_VALID      = 0;
   localparam int         ST_ORIGIN     = 1;
   localparam int         ST_SOURCE     = 2;
   localparam int         ST_RESTR      = 3;
   localparam int         ST_SLOT       = 4;
   // value is arbitrary
   localparam logic [31:0] FIXED_ID     = 32'h0000A5C3;

   // ---------------------------------------------------------------
   // invalidating event inputs, by index
   // ---------------------------------------------------------------
   localparam int EV_SLEEP  = 0;
   localparam int EV_BROWN  = 1;
   localparam int EV_WDOG   = 2;
   localparam int EV_TAMPER = 3;

   typedef enum logic [1:0] {ZONE_CFG, ZONE_OTP, ZONE_DATA} zlek_zone_t;
   typedef enum logic [1:0] {CMD_NONCE, CMD_DIGEST, CMD_MACV, CMD_OTHER} zlek_cmd_t;

endpackage

// *** hdl/zlek.sv ***
// How it works
// - legacy policy: OTP words 0 and 1 unreadable, other fourteen readable
// - legacy policy: only 4-byte OTP reads; 32-byte read returns error
// - legacy policy: every OTP write refused
// - sixteen 32-bit OTP words at 4n, all ones when delivered
// - config lock at byte 87, data/OTP lock at byte 86
// - lock bytes change only by lock command, never unlock again
// - config unlocked: any data or OTP access errors
// - config unlocked iff byte is 0x55; reads always, writes only unlocked
// - fixed config bytes never writable
// - data unlocked: reads refused, writes allowed; locked: slot config decides
// - sleep or power loss wipes ephemeral key contents
// - ephemeral key never readable by host
// - key holds 256 bits, 4-bit slot, four single flags
// - source flag 0 internal random, 1 host seed only
// - origin flag 1 means slot index meaningful
// - restricted flag set when digest used a verify-only key
// - valid cleared on power-up, sleep, brown-out, watchdog, tamper
// - other commands clear valid; CRC error leaves it alone
// - MAC-verify clears valid unless it copied into the key
// - failed seed or digest command clears valid
// - seed and digest results overwrite each other
// - key feeds crypto engines and encrypted reads and writes
// - data unlocked: OTP writable, never readable
// - locked read-only policy: OTP writes error, contents unchanged
// - consumption policy: stored word becomes old AND written
//
// Design decisions made here: the register offsets and the address-and-strobe port.
module zlek (
   input  logic                    clk,           // 250 MHz core clock
   input  logic                    reset,         // async, active high
   input  logic [7:0]              reg_addr,      // register byte address
   input  logic [31:0]             reg_wdata,     // register write data
   input  logic                    reg_wr,        // register write strobe
   input  logic                    reg_rd,        // register read strobe
   output logic [31:0]             reg_rdata,     // read data, next cycle
   input  logic                    acc_req,       // zone access request
   input  zlek_pkg::zlek_zone_t    acc_zone,      // target zone
   input  logic                    acc_write,     // 1 write, 0 read
   input  logic                    acc_len32,     // 32-byte access
   input  logic [6:0]              acc_addr,      // cfg byte or OTP word
   input  logic [31:0]             acc_wdata,     // write word
   output logic                    acc_done,      // answer pulse
   output logic                    acc_error,     // access refused
   output logic                    acc_grant,     // data access passed on
   output logic [31:0]             acc_rdata,     // read word
   input  logic                    cmd_done,      // command finished
   input  zlek_pkg::zlek_cmd_t     cmd_kind,      // which command
   input  logic                    cmd_ok,        // finished without error
   input  logic                    cmd_crc_err,   // link CRC failure
   input  logic                    cmd_copy,      // verify copied a key
   input  logic [255:0]            cmd_key,       // new key value
   input  logic [3:0]              cmd_slot,      // slot used by digest
   input  logic                    cmd_input_only,// no internal random
   input  logic                    cmd_from_slot, // digest used a slot
   input  logic                    cmd_restricted,// verify-only key used
   input  logic                    sleep_evt,     // sleep entry, async
   input  logic                    brownout_evt,  // brown-out, async
   input  logic                    watchdog_evt,  // watchdog, async
   input  logic                    tamper_evt,    // tamper, async
   output logic [255:0]            ek_key,        // to crypto engines
   output logic [3:0]              ek_slot,       // key slot index
   output logic                    ek_source,     // randomness source
   output logic                    ek_origin,     // digest origin
   output logic                    ek_restricted, // verify restricted
   output logic                    ek_valid       // key valid
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]         cfg_lock;
      logic [7:0]         data_lock;
      logic [7:0]         policy;
      logic [15:0][31:0]  otp;
      logic [3:0]         sync_a;
      logic [3:0]         sync_b;
      logic [31:0]        rdata;
      logic               done;
      logic               error;
      logic               grant;
      logic [31:0]        ardata;
      logic [255:0]       key;
      logic [3:0]         slot;
      logic               source;
      logic               origin;
      logic               restr;
      logic               valid;
   } zlek_state_t;

   zlek_state_t s;
   zlek_state_t next_s;
   logic        refuse;
   logic [3:0]  word;

   // ---------------------------------------------------------------
   // access policy
   // ---------------------------------------------------------------
   // pure decode so the verdict exists before anything is stored
   function automatic logic zlek_refused(
      input zlek_pkg::zlek_zone_t zone,
      input logic                 wr,
      input logic                 len32,
      input logic [6:0]           addr,
      input logic [7:0]           cfg_lock,
      input logic [7:0]           data_lock,
      input logic [7:0]           policy);
      logic cfg_open;
      logic data_open;
      logic r;
      cfg_open  = (cfg_lock == zlek_pkg::LOCK_OPEN);
      data_open = (data_lock == zlek_pkg::LOCK_OPEN);
      r = 1'b1;
      case (zone)
         zlek_pkg::ZONE_CFG: begin
            // fixed bytes and the lock bytes never take a write
            r = wr && (!cfg_open || addr <= zlek_pkg::CFG_FIXED_LAST
                       || addr == zlek_pkg::CFG_CFG_LOCK
                       || addr == zlek_pkg::CFG_DATA_LOCK);
         end
         zlek_pkg::ZONE_DATA: begin
            r = cfg_open || (data_open && !wr);
         end
         zlek_pkg::ZONE_OTP: begin
            if (cfg_open) begin
               r = 1'b1;
            end else if (data_open) begin
               r = !wr;
            end else begin
               case (policy)
                  zlek_pkg::POL_LEGACY: begin
                     // hidden low words, short reads only, no writes
                     r = wr || len32
                         || addr[3:0] <= zlek_pkg::LEGACY_LAST;
                  end
                  zlek_pkg::POL_CONSUME: begin
                     r = 1'b0;
                  end
                  default: begin
                     r = wr;
                  end
               endcase
            end
         end
         default: begin
            r = 1'b1;
         end
      endcase
      return r;
   endfunction

   // config zone read view; other bytes live outside this block
   function automatic logic [7:0] zlek_cfg_byte(
      input logic [6:0] addr,
      input logic [7:0] cfg_lock,
      input logic [7:0] data_lock,
      input logic [7:0] policy);
      logic [7:0] b;
      b = 8'h00;
      case (addr)
         zlek_pkg::CFG_CFG_LOCK:  b = cfg_lock;
         zlek_pkg::CFG_DATA_LOCK: b = data_lock;
         zlek_pkg::CFG_POLICY:    b = policy;
         default:                 b = 8'h00;
      endcase
      return b;
   endfunction

   assign word   = acc_addr[3:0];
   assign refuse = zlek_refused(acc_zone, acc_write, acc_len32, acc_addr,
                                s.cfg_lock, s.data_lock, s.policy);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      // event pins pass two flops before anything looks at them
      next_s.sync_a = {tamper_evt, watchdog_evt, brownout_evt, sleep_evt};
      next_s.sync_b = s.sync_a;

      // zone access: verdict first, store only when accepted
      next_s.done   = acc_req;
      next_s.error  = acc_req && refuse;
      next_s.grant  = 1'b0;
      next_s.ardata = 32'h00000000;
      if (acc_req && !refuse) begin
         case (acc_zone)
            zlek_pkg::ZONE_CFG: begin
               if (!acc_write) begin
                  next_s.ardata = {24'h000000, zlek_cfg_byte(acc_addr,
                                   s.cfg_lock, s.data_lock, s.policy)};
               end else if (acc_addr == zlek_pkg::CFG_POLICY) begin
                  next_s.policy = acc_wdata[7:0];
               end
            end
            zlek_pkg::ZONE_OTP: begin
               if (!acc_write) begin
                  next_s.ardata = s.otp[word];
               end else if (s.data_lock == zlek_pkg::LOCK_OPEN) begin
                  next_s.otp[word] = acc_wdata;
               end else begin
                  // fuses: bits only fall from one to zero
                  next_s.otp[word] = s.otp[word] & acc_wdata;
               end
            end
            zlek_pkg::ZONE_DATA: begin
               next_s.grant = 1'b1;
            end
            default: begin
               next_s.grant = 1'b0;
            end
         endcase
      end

      // register port reads; the key itself has no read path
      next_s.rdata = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            zlek_pkg::REG_CFG_LOCK:  next_s.rdata = {24'h000000, s.cfg_lock};
            zlek_pkg::REG_DATA_LOCK: next_s.rdata = {24'h000000, s.data_lock};
            zlek_pkg::REG_POLICY:    next_s.rdata = {24'h000000, s.policy};
            zlek_pkg::REG_FIXED:     next_s.rdata = zlek_pkg::FIXED_ID;
            zlek_pkg::REG_STATUS: begin
               next_s.rdata[zlek_pkg::ST_VALID]  = s.valid;
               next_s.rdata[zlek_pkg::ST_ORIGIN] = s.origin;
               next_s.rdata[zlek_pkg::ST_SOURCE] = s.source;
               next_s.rdata[zlek_pkg::ST_RESTR]  = s.restr;
               next_s.rdata[zlek_pkg::ST_SLOT+:4] = s.slot;
            end
            default: next_s.rdata = 32'h00000000;
         endcase
      end

      // register writes: policy while config open, lock command
      if (reg_wr) begin
         case (reg_addr)
            zlek_pkg::REG_POLICY: begin
               if (s.cfg_lock == zlek_pkg::LOCK_OPEN) begin
                  next_s.policy = reg_wdata[7:0];
               end
            end
            zlek_pkg::REG_LOCK_CMD: begin
               // one-way: lock command only ever writes the shut value
               if (reg_wdata[zlek_pkg::LOCKCMD_CFG]) begin
                  next_s.cfg_lock = zlek_pkg::LOCK_SHUT;
               end
               if (reg_wdata[zlek_pkg::LOCKCMD_DATA] &&
                   s.cfg_lock != zlek_pkg::LOCK_OPEN) begin
                  next_s.data_lock = zlek_pkg::LOCK_SHUT;
               end
            end
            default: begin
               next_s.policy = next_s.policy;
            end
         endcase
      end

      // ephemeral key update at command end
      if (cmd_done && !cmd_crc_err) begin
         case (cmd_kind)
            zlek_pkg::CMD_NONCE: begin
               if (cmd_ok) begin
                  next_s.key    = cmd_key;
                  next_s.source = cmd_input_only;
                  next_s.origin = 1'b0;
                  next_s.restr  = 1'b0;
                  next_s.slot   = 4'h0;
                  next_s.valid  = 1'b1;
               end else begin
                  next_s.valid  = 1'b0;
               end
            end
            zlek_pkg::CMD_DIGEST: begin
               if (cmd_ok) begin
                  next_s.key    = cmd_key;
                  next_s.origin = cmd_from_slot;
                  next_s.slot   = cmd_slot;
                  next_s.restr  = cmd_restricted;
                  next_s.valid  = 1'b1;
               end else begin
                  next_s.valid  = 1'b0;
               end
            end
            zlek_pkg::CMD_MACV: begin
               if (cmd_ok && cmd_copy) begin
                  next_s.key    = cmd_key;
                  next_s.valid  = 1'b1;
               end else begin
                  next_s.valid  = 1'b0;
               end
            end
            default: begin
               next_s.valid = 1'b0;
            end
         endcase
      end

      // invalidating events win over any load in the same cycle
      if (|s.sync_b) begin
         next_s.valid = 1'b0;
      end
      if (s.sync_b[zlek_pkg::EV_SLEEP] || s.sync_b[zlek_pkg::EV_BROWN]) begin
         next_s.key    = '0;
         next_s.slot   = 4'h0;
         next_s.source = 1'b0;
         next_s.origin = 1'b0;
         next_s.restr  = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // power-up is the reset: key wiped, invalid, OTP as delivered
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s           <= '0;
         s.cfg_lock  <= zlek_pkg::LOCK_OPEN;
         s.data_lock <= zlek_pkg::LOCK_OPEN;
         s.policy    <= zlek_pkg::POL_RESET;
         s.otp       <= {zlek_pkg::OTP_WORDS{zlek_pkg::OTP_RESET}};
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata     = s.rdata;
   assign acc_done      = s.done;
   assign acc_error     = s.error;
   assign acc_grant     = s.grant;
   assign acc_rdata     = s.ardata;
   assign ek_key        = s.key;
   assign ek_slot       = s.slot;
   assign ek_source     = s.source;
   assign ek_origin     = s.origin;
   assign ek_restricted = s.restr;
   assign ek_valid      = s.valid;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   logic legacy_on;
   assign legacy_on = s.cfg_lock != zlek_pkg::LOCK_OPEN &&
                      s.data_lock != zlek_pkg::LOCK_OPEN &&
                      s.policy == zlek_pkg::POL_LEGACY;

   sequence otp_fuse_write;
      acc_req && acc_zone == zlek_pkg::ZONE_OTP && acc_write && !refuse &&
      s.data_lock != zlek_pkg::LOCK_OPEN;
   endsequence

   sequence key_cleared;
      !ek_valid && ek_key == '0;
   endsequence

   AST_LEGACY_LOW: assert property (
      acc_req && acc_zone == zlek_pkg::ZONE_OTP && !acc_write && legacy_on
      && !acc_len32 |=> acc_done && (acc_error == ($past(word) <= 4'h1)))
      else $error("legacy low word read not handled");

   AST_LEGACY_LONG: assert property (
      acc_req && acc_zone == zlek_pkg::ZONE_OTP && acc_len32 && legacy_on
      |=> acc_error)
      else $error("legacy 32-byte read accepted");

   AST_LEGACY_NOWR: assert property (
      acc_req && acc_zone == zlek_pkg::ZONE_OTP && acc_write && legacy_on
      |=> acc_error && s.otp == $past(s.otp))
      else $error("legacy OTP write accepted");

   AST_LOCK_STAYS: assert property (
      s.cfg_lock != zlek_pkg::LOCK_OPEN |=> s.cfg_lock == $past(s.cfg_lock))
      else $error("config lock reopened");

   AST_CFG_OPEN_BLOCK: assert property (
      acc_req && acc_zone != zlek_pkg::ZONE_CFG &&
      s.cfg_lock == zlek_pkg::LOCK_OPEN |=> acc_error && !acc_grant)
      else $error("zone access while config open");

   AST_FUSE_AND: assert property (
      otp_fuse_write |=> s.otp[$past(word)] ==
      ($past(s.otp[word]) & $past(acc_wdata)))
      else $error("fuse write not an AND");

   AST_OTHER_CLEARS: assert property (
      cmd_done && !cmd_crc_err && cmd_kind == zlek_pkg::CMD_OTHER |=> !ek_valid)
      else $error("valid kept after other command");

   AST_CRC_KEEPS: assert property (
      cmd_done && cmd_crc_err && s.sync_b == 4'h0 |=> $stable(ek_valid))
      else $error("CRC error changed valid");

   AST_SLEEP_WIPES: assert property (
      sleep_evt |-> ##3 key_cleared)
      else $error("sleep did not wipe key");

endmodule

// *** testbench/zlek_host.sv ***
module zlek_host (
   input  wire logic          clk,            // core clock
   input  wire logic          run,            // host keeps issuing commands
   output zlek_pkg::zlek_cmd_t cmd_kind,      // finished command
   output logic               cmd_done,       // completion pulse
   output logic               cmd_ok,         // no error
   output logic               cmd_crc_err,    // link error
   output logic               cmd_copy,       // verify copied a key
   output logic [255:0]       cmd_key,        // result value
   output logic [3:0]         cmd_slot,       // slot used
   output logic               cmd_input_only, // seed only
   output logic               cmd_from_slot,  // digest from a slot
   output logic               cmd_restricted  // verify-only key used
);
   timeunit 1ns;
   timeprecision 1ps;

   // quiet at time zero
   initial begin
      {cmd_done, cmd_ok, cmd_crc_err, cmd_copy, cmd_slot, cmd_input_only, cmd_from_slot, cmd_restricted} = '0;
      cmd_kind = zlek_pkg::CMD_OTHER;
      cmd_key = '0;
   end

   // qualifiers change every cycle, so only the value beside the pulse means anything
   always @(posedge clk) begin
      cmd_done <= run & 1'($urandom_range(1, 0));
      cmd_kind <= zlek_pkg::zlek_cmd_t'($urandom_range(3, 0));
      cmd_ok <= ($urandom_range(3, 0) != 0);
      cmd_crc_err <= ($urandom_range(7, 0) == 0);
      {cmd_copy, cmd_input_only, cmd_from_slot, cmd_restricted, cmd_slot} <= 8'($urandom());
      cmd_key <= {8{$urandom()}};
   end
endmodule

// *** testbench/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, reg_wr, reg_rd, acc_req, acc_write, acc_len32, run, due, m_val, m_new, m_dig, leg;
   logic sleep_evt, brownout_evt, watchdog_evt, tamper_evt, acc_done, acc_error, acc_grant, cmd_done, cmd_ok;
   logic cmd_crc_err, cmd_copy, cmd_input_only, cmd_from_slot, cmd_restricted, ek_source, ek_origin;
   logic ek_restricted, ek_valid;
   logic [7:0]   reg_addr, p, pols [3];
   logic [31:0]  reg_wdata, acc_wdata, reg_rdata, acc_rdata, d, otp_m [16];
   logic [6:0]   acc_addr;
   logic [3:0]   cmd_slot, ek_slot;
   logic [7:0]   f;
   logic [255:0] cmd_key, ek_key, m_key, keep;
   zlek_pkg::zlek_zone_t acc_zone;
   zlek_pkg::zlek_cmd_t  cmd_kind;
   int failures, num_checks;

   zlek i_zlek (.*);
   zlek_host i_zlek_host (.*);

   // free-running core clock
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      // one idle edge so a following write never re-raises the strobe in the same step
      @(posedge clk);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      chk("reg_rdata", reg_rdata, e);
      @(posedge clk);
   endtask

   task automatic acc(input zlek_pkg::zlek_zone_t z, input logic w, l, input logic [6:0] a,
                      input logic [31:0] v, input logic e, input logic [31:0] r, input logic g);
      acc_zone <= z;
      {acc_write, acc_len32, acc_addr, acc_wdata, acc_req} <= {w, l, a, v, 1'h1};
      @(posedge clk);
      acc_req <= 1'h0;
      @(negedge clk);
      chk("acc_done", acc_done, 1'h1);
      chk("acc_error", acc_error, e);
      chk("acc_rdata", acc_rdata, r);
      chk("acc_grant", acc_grant, g);
      @(posedge clk);
   endtask

   // reference key state, taken from what the host hands over at each edge
   always @(posedge clk) begin
      if (reset) m_val = 1'h0;
      else if (cmd_done) begin
         due = 1'h1;
         m_dig = (cmd_kind == zlek_pkg::CMD_DIGEST);
         m_new = cmd_ok && !cmd_crc_err && (m_dig || cmd_kind == zlek_pkg::CMD_NONCE);
         f = {cmd_input_only, cmd_from_slot, cmd_restricted, 1'h0, cmd_slot};
         if (!cmd_crc_err) m_val = cmd_ok && cmd_kind != zlek_pkg::CMD_OTHER && (cmd_kind != zlek_pkg::CMD_MACV || cmd_copy);
         if (m_val && !cmd_crc_err) m_key = cmd_key;
      end
   end

   // compare once the update has landed
   always @(negedge clk) if (due) begin
      due = 1'h0;
      chk("ek_valid", ek_valid, m_val);
      if (m_val) chk("ek_key", ek_key, m_key);
      if (m_new) chk("ek_origin", ek_origin, m_dig & f[6]);
      if (m_new) chk("ek_restricted", ek_restricted, m_dig & f[5]);
      if (m_new && !m_dig) chk("ek_source", ek_source, f[7]);
      if (m_new && m_dig && f[6]) chk("ek_slot", ek_slot, f[3:0]);
   end

   // hang guard
   initial begin
      #400000;
      failures++;
      final_report();
   end

   initial begin
      void'($urandom(32'hD3AF52D0));
      {reset, reg_wr, reg_rd, acc_req, acc_write, acc_len32, run, due, m_val} = 9'h100;
      {sleep_evt, brownout_evt, watchdog_evt, tamper_evt, reg_addr, reg_wdata, acc_addr, acc_wdata} = '0;
      acc_zone = zlek_pkg::ZONE_CFG;
      m_key = '0;
      pols = '{zlek_pkg::POL_LEGACY, zlek_pkg::POL_CONSUME, zlek_pkg::POL_READONLY};
      for (int k = 0; k < 3; k++) begin
         p = pols[k];
         leg = (p == zlek_pkg::POL_LEGACY);
         reset <= 1'h1;
         repeat (2) @(posedge clk);
         reset <= 1'h0;
         for (int i = 0; i < 16; i++) otp_m[i] = zlek_pkg::OTP_RESET;
         rd(zlek_pkg::REG_CFG_LOCK, zlek_pkg::LOCK_OPEN);
         rd(zlek_pkg::REG_FIXED, zlek_pkg::FIXED_ID);
         rd(8'hFC, 32'h0);
         wr(zlek_pkg::REG_CFG_LOCK, 32'h0);
         rd(zlek_pkg::REG_CFG_LOCK, zlek_pkg::LOCK_OPEN);
         acc(zlek_pkg::ZONE_OTP, 1'h0, 1'h0, 7'h02, 32'h0, 1'h1, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_DATA, 1'h1, 1'h0, 7'h00, 32'h0, 1'h1, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_CFG, 1'h1, 1'h0, zlek_pkg::CFG_FIXED_LAST, 32'h0, 1'h1, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_CFG, 1'h1, 1'h0, zlek_pkg::CFG_DATA_LOCK, 32'h0, 1'h1, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_CFG, 1'h1, 1'h0, zlek_pkg::CFG_POLICY, 32'h3C, 1'h0, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_CFG, 1'h0, 1'h0, zlek_pkg::CFG_POLICY, 32'h0, 1'h0, 32'h3C, 1'h0);
         wr(zlek_pkg::REG_POLICY, {24'h0, p});
         wr(zlek_pkg::REG_LOCK_CMD, 32'h1);
         rd(zlek_pkg::REG_CFG_LOCK, zlek_pkg::LOCK_SHUT);
         acc(zlek_pkg::ZONE_CFG, 1'h1, 1'h0, zlek_pkg::CFG_POLICY, 32'h0, 1'h1, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_CFG, 1'h0, 1'h0, zlek_pkg::CFG_POLICY, 32'h0, 1'h0, {24'h0, p}, 1'h0);
         wr(zlek_pkg::REG_POLICY, {24'h0, ~p});
         rd(zlek_pkg::REG_POLICY, {24'h0, p});
         d = $urandom();
         otp_m[3] = d;
         acc(zlek_pkg::ZONE_OTP, 1'h1, 1'h0, 7'h03, d, 1'h0, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_OTP, 1'h0, 1'h0, 7'h03, 32'h0, 1'h1, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_DATA, 1'h0, 1'h0, 7'h00, 32'h0, 1'h1, 32'h0, 1'h0);
         acc(zlek_pkg::ZONE_DATA, 1'h1, 1'h0, 7'h00, d, 1'h0, 32'h0, 1'h1);
         wr(zlek_pkg::REG_LOCK_CMD, 32'h2);
         rd(zlek_pkg::REG_DATA_LOCK, zlek_pkg::LOCK_SHUT);
         for (int w = 0; w < 16; w++)
            acc(zlek_pkg::ZONE_OTP, 1'h0, 1'h0, 7'(w), 32'h0, leg && w < 2, (leg && w < 2) ? 32'h0 : otp_m[w], 1'h0);
         acc(zlek_pkg::ZONE_OTP, 1'h0, 1'h1, 7'h05, 32'h0, leg, leg ? 32'h0 : otp_m[5], 1'h0);
         d = $urandom();
         acc(zlek_pkg::ZONE_OTP, 1'h1, 1'h0, 7'h03, d, p != zlek_pkg::POL_CONSUME, 32'h0, 1'h0);
         if (p == zlek_pkg::POL_CONSUME) otp_m[3] &= d;
         acc(zlek_pkg::ZONE_OTP, 1'h0, 1'h0, 7'h03, 32'h0, 1'h0, otp_m[3], 1'h0);
      end
      // each event must drop valid two edges after it is seen; sleep and brown-out also wipe
      for (int e = 0; e < 4; e++) begin
         for (int t = 0; t < 40 && !(m_val && t > 0); t++) begin
            run <= 1'h1;
            repeat (20) @(posedge clk);
            run <= 1'h0;
            repeat (3) @(posedge clk);
         end
         if (!m_val) begin
            failures++;
            break;
         end
         keep = m_key;
         {tamper_evt, watchdog_evt, brownout_evt, sleep_evt} <= 4'h1 << e;
         @(posedge clk);
         {tamper_evt, watchdog_evt, brownout_evt, sleep_evt} <= 4'h0;
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk("ek_valid", ek_valid, 1'h0);
         chk("ek_key", ek_key, (e <= zlek_pkg::EV_BROWN) ? 256'h0 : keep);
         m_val = 1'h0;
         m_key = ek_key;
         @(posedge clk);
         // a wiping event leaves every status field at zero, and no key bit shows there
         if (e <= zlek_pkg::EV_BROWN) rd(zlek_pkg::REG_STATUS, 32'h0);
      end
      final_report();
   end
endmodule
